// >>> hdl/rxf_pkg.sv
// Purpose: shared constants and types of the receive FIFO read-out block
// Assumes: 32-bit APB register port, byte addresses below
// Notes: FIFO depths are fixed

package rxf_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_DATA_PORT = 8'h00;
  localparam logic [7:0] ADDR_STAT_PORT = 8'h04;
  localparam logic [7:0] ADDR_RX_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_DP_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_FILL_INFO = 8'h10;
  localparam logic [7:0] ADDR_MAC_CTRL = 8'h14;
  localparam logic [7:0] ADDR_EVENTS = 8'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CFG_OFF_LSB = 0;
  localparam int CFG_BURST_LSB = 8;
  localparam int CFG_DUMP_BIT = 15;
  localparam int DP_SKIP_BIT = 31;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  localparam int EVT_ERR_BIT = 0;
  localparam int EVT_HALT_BIT = 1;
  localparam int INFO_STAT_LSB = 16;
  localparam int STAT_LEN_LSB = 16;

  // ****************************************
  // values after reset and sizes
  // ****************************************
  localparam logic [4:0] OFF_RESET = 5'h00;
  localparam logic [4:0] BURST_RESET = 5'h00;
  localparam int DATA_AW = 10;
  localparam int STAT_AW = 4;
  localparam logic [2:0] BYTES_PER_WORD = 3'h4;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic valid;
    logic last;
    logic [2:0] nbytes;
    logic [31:0] data;
    logic [31:0] status;
  } rxf_mac_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_LEAD = 6'b000010,
    ST_DATA = 6'b000100,
    ST_TAIL = 6'b001000,
    ST_PAD = 6'b010000,
    ST_STAT = 6'b100000
  } rxf_state_t;

  typedef enum logic [1:0] {
    SRC_REG = 2'b00,
    SRC_DATA = 2'b01,
    SRC_STAT = 2'b10
  } rxf_src_t;

endpackage

// >>> hdl/rxf_mem.sv
// Purpose: simple dual-port storage for the receive FIFOs
// Assumes: one write and one read per cycle
// Notes: read data come out of a register one cycle after the read

`timescale 1ns/1ps

module rxf_mem #(
  parameter int WIDTH = 33,
  parameter int AW = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read side
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// >>> hdl/rxf_top.sv
// Purpose: receive data and status FIFOs with host read-out over APB
// Assumes: mac side delivers whole words, last word carries byte count
// Notes: every APB access has one wait state; FIFO reads pop at once

`timescale 1ns/1ps

module rxf_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // mac receive side
  input wire rxf_pkg::rxf_mac_t MAC_RX,
  output logic MAC_READY,
  // events
  output logic RX_ERROR,
  output logic RX_HALTED
);
  import rxf_pkg::*;

  // ****************************************
  // state and registers
  // ****************************************
  rxf_state_t st_reg, st_next;
  rxf_src_t src_reg;
  logic ack_reg, soft_reg, dump_reg, skip_reg, skip_wait_reg;
  logic rx_en_reg, rx_on_reg, err_reg, halt_ev_reg, halt_pulse_reg;
  logic [4:0] cfg_off_reg, cfg_burst_reg, off_reg, burst_reg, pos_reg;
  logic [2:0] lead_reg;
  logic [13:0] len_reg;
  logic [31:0] carry_reg, stat_word_reg, prdata_reg;
  logic [DATA_AW:0] dwptr_reg, drptr_reg;
  logic [STAT_AW:0] swptr_reg, srptr_reg;
  logic [32:0] drdata;
  logic [31:0] srdata;

  function automatic logic [4:0] pos_step(input logic [4:0] pos,
                                          input logic [4:0] burst);
    pos_step = (pos + 5'h01 == burst) ? 5'h00 : pos + 5'h01;
  endfunction

  // ****************************************
  // fill levels
  // ****************************************
  wire [DATA_AW:0] dused = dwptr_reg - drptr_reg;
  wire [STAT_AW:0] sused = swptr_reg - srptr_reg;
  wire dfull = dused[DATA_AW];
  wire dempty = (dused == '0);
  wire sfull = sused[STAT_AW];
  wire sempty = (sused == '0);
  wire flush = soft_reg | dump_reg;

  // ****************************************
  // apb decode
  // ****************************************
  wire acc1 = PSEL & PENABLE & ~ack_reg;
  wire rd1 = acc1 & ~PWRITE;
  wire wr_fire = PSEL & PENABLE & ack_reg & PWRITE;
  wire a_data = (PADDR == ADDR_DATA_PORT);
  wire a_stat = (PADDR == ADDR_STAT_PORT);
  wire a_cfg = (PADDR == ADDR_RX_CONFIG);
  wire a_dp = (PADDR == ADDR_DP_CTRL);
  wire a_info = (PADDR == ADDR_FILL_INFO);
  wire a_ctrl = (PADDR == ADDR_MAC_CTRL);
  wire a_evt = (PADDR == ADDR_EVENTS);
  wire hit = a_data | a_stat | a_cfg | a_dp | a_info | a_ctrl | a_evt;

  // ****************************************
  // fifo read side
  // ****************************************
  // host data reads pop nothing and return zero while a skip owns the read port
  wire dre_host = rd1 & a_data & ~dempty & ~skip_reg;
  wire dre_skip = skip_reg & ~skip_wait_reg & ~dempty;
  wire dre = (dre_host | dre_skip) & ~flush;
  wire sre = rd1 & a_stat & ~sempty & ~flush;
  wire d_under = rd1 & a_data & dempty;
  wire s_under = rd1 & a_stat & sempty;
  // the skip looks only at the last-word flag of the word just popped
  wire skip_done = skip_reg & skip_wait_reg & drdata[32];

  // ****************************************
  // fill information and register reads
  // ****************************************
  wire [31:0] info_word = {8'h00, 3'h0, sused, 3'h0, dused, 2'h0};
  wire [31:0] cfg_word = {16'h0000, dump_reg, 2'h0, cfg_burst_reg,
                          3'h0, cfg_off_reg};
  wire [31:0] rd_word =
    a_cfg ? cfg_word :
    a_dp ? {skip_reg, 31'h0} :
    a_info ? info_word :
    a_ctrl ? {30'h0, soft_reg, rx_en_reg} :
    a_evt ? {30'h0, halt_ev_reg, err_reg} : 32'h0;

  // ****************************************
  // receive write side
  // ****************************************
  wire [63:0] shifted = {32'h0, MAC_RX.data} << {off_reg[1:0], 3'b000};
  wire [3:0] tail_sum = {2'b00, off_reg[1:0]} + {1'b0, MAC_RX.nbytes};
  wire tail_need = (tail_sum > {1'b0, BYTES_PER_WORD});
  wire [4:0] pos_nx = pos_step(pos_reg, burst_reg);
  wire pad_after = (burst_reg != 5'h00) & (pos_nx != 5'h00);
  wire [13:0] len_nx = len_reg + {11'h0, MAC_RX.nbytes};
  logic dwe, dlast, swe;
  logic [31:0] dwword;

  always_comb begin
    st_next = st_reg;
    dwe = 1'b0;
    dlast = 1'b0;
    dwword = 32'h0;
    swe = 1'b0;
    MAC_READY = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        // a cleared enable stops new frames before the halt pulse
        if (MAC_RX.valid & rx_on_reg & rx_en_reg) begin
          st_next = (cfg_off_reg[4:2] != 3'h0) ? ST_LEAD : ST_DATA;
        end
      end
      ST_LEAD: begin
        dwe = ~dfull;
        if (~dfull & (lead_reg == off_reg[4:2] - 3'h1)) begin
          st_next = ST_DATA;
        end
      end
      ST_DATA: begin
        MAC_READY = ~dfull;
        if (MAC_RX.valid & ~dfull) begin
          dwe = 1'b1;
          // bytes pushed out of the previous word fill the low lanes
          dwword = shifted[31:0] | carry_reg;
          if (MAC_RX.last) begin
            if (tail_need) begin
              st_next = ST_TAIL;
            end else if (pad_after) begin
              st_next = ST_PAD;
            end else begin
              dlast = 1'b1;
              st_next = ST_STAT;
            end
          end
        end
      end
      ST_TAIL: begin
        dwe = ~dfull;
        dwword = carry_reg;
        if (~dfull) begin
          dlast = ~pad_after;
          st_next = pad_after ? ST_PAD : ST_STAT;
        end
      end
      ST_PAD: begin
        dwe = ~dfull;
        if (~dfull & (pos_nx == 5'h00)) begin
          dlast = 1'b1;
          st_next = ST_STAT;
        end
      end
      ST_STAT: begin
        // a full status FIFO drops the word and flags an overrun
        swe = ~sfull;
        st_next = ST_IDLE;
      end
    endcase
  end

  wire s_over = (st_reg == ST_STAT) & sfull;

  // ****************************************
  // storage
  // ****************************************
  rxf_mem #(.WIDTH(33), .AW(DATA_AW)) u_data_mem (
    .clk(CLOCK),
    .rst_n(RSTN),
    .we(dwe),
    .waddr(dwptr_reg[DATA_AW-1:0]),
    .wdata({dlast, dwword}),
    .re(dre),
    .raddr(drptr_reg[DATA_AW-1:0]),
    .rdata(drdata)
  );

  rxf_mem #(.WIDTH(32), .AW(STAT_AW)) u_stat_mem (
    .clk(CLOCK),
    .rst_n(RSTN),
    .we(swe),
    .waddr(swptr_reg[STAT_AW-1:0]),
    .wdata(stat_word_reg),
    .re(sre),
    .raddr(srptr_reg[STAT_AW-1:0]),
    .rdata(srdata)
  );

  // ****************************************
  // pointers
  // ****************************************
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      dwptr_reg <= '0;
      drptr_reg <= '0;
      swptr_reg <= '0;
      srptr_reg <= '0;
    end else if (flush) begin
      dwptr_reg <= '0;
      drptr_reg <= '0;
      swptr_reg <= '0;
      srptr_reg <= '0;
    end else begin
      dwptr_reg <= dwptr_reg + {{DATA_AW{1'b0}}, dwe};
      drptr_reg <= drptr_reg + {{DATA_AW{1'b0}}, dre};
      swptr_reg <= swptr_reg + {{STAT_AW{1'b0}}, swe};
      srptr_reg <= srptr_reg + {{STAT_AW{1'b0}}, sre};
    end
  end

  // ****************************************
  // frame assembly
  // ****************************************
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= ST_IDLE;
      off_reg <= OFF_RESET;
      burst_reg <= BURST_RESET;
      pos_reg <= 5'h00;
      lead_reg <= 3'h0;
      len_reg <= 14'h0000;
      carry_reg <= 32'h0;
      stat_word_reg <= 32'h0;
    end else if (soft_reg) begin
      st_reg <= ST_IDLE;
    end else begin
      st_reg <= st_next;
      if (st_reg == ST_IDLE) begin
        // settings are frozen per packet so each one is framed alone
        off_reg <= cfg_off_reg;
        burst_reg <= cfg_burst_reg;
        pos_reg <= 5'h00;
        lead_reg <= 3'h0;
        len_reg <= 14'h0000;
        carry_reg <= 32'h0;
      end else if (dwe) begin
        pos_reg <= pos_nx;
        lead_reg <= lead_reg + 3'h1;
      end
      if ((st_reg == ST_DATA) & dwe) begin
        carry_reg <= shifted[63:32];
        len_reg <= len_nx;
        if (MAC_RX.last) begin
          stat_word_reg <= {MAC_RX.status[31:30], len_nx,
                            MAC_RX.status[15:0]};
        end
      end
    end
  end

  // ****************************************
  // apb answer and control registers
  // ****************************************
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ack_reg <= 1'b0;
      src_reg <= SRC_REG;
      prdata_reg <= 32'h0;
    end else begin
      ack_reg <= acc1;
      if (rd1) begin
        src_reg <= dre_host ? SRC_DATA : (sre ? SRC_STAT : SRC_REG);
        prdata_reg <= rd_word;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_off_reg <= OFF_RESET;
      cfg_burst_reg <= BURST_RESET;
      rx_en_reg <= 1'b0;
      rx_on_reg <= 1'b0;
      soft_reg <= 1'b0;
      dump_reg <= 1'b0;
      skip_reg <= 1'b0;
      skip_wait_reg <= 1'b0;
      err_reg <= 1'b0;
      halt_ev_reg <= 1'b0;
      halt_pulse_reg <= 1'b0;
    end else if (soft_reg) begin
      cfg_off_reg <= OFF_RESET;
      cfg_burst_reg <= BURST_RESET;
      rx_en_reg <= 1'b0;
      rx_on_reg <= 1'b0;
      soft_reg <= 1'b0;
      dump_reg <= 1'b0;
      skip_reg <= 1'b0;
      skip_wait_reg <= 1'b0;
      err_reg <= 1'b0;
      halt_ev_reg <= 1'b0;
      halt_pulse_reg <= 1'b0;
    end else begin
      if (wr_fire & a_cfg) begin
        cfg_off_reg <= PWDATA[CFG_OFF_LSB +: 5];
        cfg_burst_reg <= PWDATA[CFG_BURST_LSB +: 5];
      end
      if (wr_fire & a_ctrl) begin
        rx_en_reg <= PWDATA[CTRL_EN_BIT];
      end
      soft_reg <= wr_fire & a_ctrl & PWDATA[CTRL_SRST_BIT];
      // dump finishes in the cycle after it is set
      dump_reg <= wr_fire & a_cfg & PWDATA[CFG_DUMP_BIT];
      if (wr_fire & a_dp & PWDATA[DP_SKIP_BIT]) begin
        skip_reg <= 1'b1;
      end else if (skip_done | dump_reg) begin
        skip_reg <= 1'b0;
      end
      skip_wait_reg <= dre_skip & ~flush;
      // a new error in the clearing cycle wins over the clear
      err_reg <= (err_reg & ~(wr_fire & a_evt & PWDATA[EVT_ERR_BIT]))
                 | d_under | s_under | s_over;
      halt_pulse_reg <= 1'b0;
      if (rx_en_reg) begin
        rx_on_reg <= 1'b1;
      end else if (rx_on_reg & (st_reg == ST_IDLE)) begin
        rx_on_reg <= 1'b0;
        halt_pulse_reg <= 1'b1;
      end
      halt_ev_reg <= (halt_ev_reg & ~(wr_fire & a_evt &
                     PWDATA[EVT_HALT_BIT])) | halt_pulse_reg;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PREADY = ack_reg;
  assign PSLVERR = ack_reg & ~hit;
  assign PRDATA = (src_reg == SRC_DATA) ? drdata[31:0] :
                  (src_reg == SRC_STAT) ? srdata : prdata_reg;
  assign RX_ERROR = err_reg;
  assign RX_HALTED = halt_pulse_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  chk_data_push: assert property (
    dwe & ~flush |=> dwptr_reg == $past(dwptr_reg) + 1'b1)
    else $error("data write pointer did not advance");
  chk_status_slot: assert property (
    swe |-> st_reg == ST_STAT && $past(st_reg) != ST_IDLE)
    else $error("status written outside its slot");
  chk_info_count: assert property (
    rd1 & a_info & ~flush |=> PRDATA[23:16] == 8'($past(sused)))
    else $error("fill info status count wrong");
  chk_underrun_err: assert property (
    d_under | s_under |=> err_reg)
    else $error("underrun did not raise error");
  chk_error_sticky: assert property (
    err_reg & ~soft_reg & ~(wr_fire & a_evt) |=> err_reg)
    else $error("error flag dropped by itself");
  chk_lead_zero: assert property (
    st_reg == ST_LEAD & dwe |-> dwword == 32'h0)
    else $error("offset word not zero");
  chk_pad_whole: assert property (
    st_reg == ST_STAT & burst_reg != 5'h00 |-> pos_reg == 5'h00)
    else $error("packet not padded to burst");
  chk_skip_status: assert property (
    skip_reg & ~sre & ~flush |=> srptr_reg == $past(srptr_reg))
    else $error("skip moved status FIFO");
  chk_skip_clear: assert property (
    skip_done & ~soft_reg & ~(wr_fire & a_dp) |=> ~skip_reg)
    else $error("skip bit not cleared");
  chk_dump_flush: assert property (
    dump_reg |=> ~dump_reg && dwptr_reg == '0 && srptr_reg == '0)
    else $error("dump did not flush");
  chk_halt_pulse: assert property (
    RX_HALTED |-> $past(rx_on_reg) && !rx_on_reg ##1 !RX_HALTED)
    else $error("halt event not a single pulse");

endmodule

// >>> verif/rxf_mac_model.sv
// Purpose: behavioural frame source on the mac receive side of rxf_top
// Assumes: whole 4-byte words, status handed with the last word
// Notes: released lines show the inverse of the last word, not zeros

`timescale 1ns/1ps

module rxf_mac_model (
  // clock
  input wire logic clk,
  // link to the block
  output rxf_pkg::rxf_mac_t mac_rx,
  input wire logic mac_ready
);
  import rxf_pkg::*;

  // ****************************************
  // frame sender
  // ****************************************
  initial mac_rx = '0;

  // words go back to back; each is held until an edge samples ready high
  task automatic send(input int n, input logic [31:0] base,
                      input logic [31:0] stat);
    int k;
    logic [31:0] w;
    @(posedge clk);
    for (k = 0; k < n; k++) begin
      w = base + 32'(k);
      mac_rx <= {1'b1, k == n - 1, 3'h4, w, stat};
      do @(posedge clk); while (mac_ready !== 1'b1);
    end
    // a stale word must never pass for a fresh one
    mac_rx <= {1'b0, 1'b0, 3'h0, ~w, ~stat};
  endtask
endmodule

// >>> verif/tb.sv
// Purpose: self-checking bench of rxf_top over its apb port
// Assumes: one wait state per access, fill info as in the package
// Notes: mac traffic comes from rxf_mac_model

`timescale 1ns/1ps

module tb;
  import rxf_pkg::*;

  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic mac_ready, rx_error, rx_halted, e, halt_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  rxf_mac_t mac_rx;
  int failures, checks_done, cycles, i, p;

  rxf_top u_rxf_top (
    .CLOCK(clk), .RSTN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MAC_RX(mac_rx),
    .MAC_READY(mac_ready), .RX_ERROR(rx_error), .RX_HALTED(rx_halted)
  );

  rxf_mac_model u_rxf_mac_model (
    .clk(clk), .mac_rx(mac_rx), .mac_ready(mac_ready)
  );

  // ****************************************
  // bus tasks and helpers
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  function automatic logic [31:0] fi(input int s, input int w);
    fi = {11'h0, 5'(s), 3'h0, 11'(w), 2'h0};
  endfunction

  // the block must overwrite bits 29:16 with its own byte count
  function automatic logic [31:0] st(input int len);
    st = {2'b01, 14'(len), 16'h00a5};
  endfunction

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // clock, timeout, halt watch
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rx_halted === 1'b1) halt_seen <= 1'b1;
    if (cycles == 20000) begin
      failures = failures + 1;
      wrap_up;
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    halt_seen = 1'b0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_FILL_INFO, 32'h0);
    rd_chk(ADDR_EVENTS, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, e}, 32'h1);
    end_test("reset");

    apb(1'b1, ADDR_MAC_CTRL, 32'h1);
    u_rxf_mac_model.send(3, 32'h1000, 32'h7fff_00a5);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_FILL_INFO, fi(1, 3));
    rd_chk(ADDR_STAT_PORT, st(12));
    for (i = 0; i < 3; i++) rd_chk(ADDR_DATA_PORT, 32'h1000 + i);
    rd_chk(ADDR_FILL_INFO, 32'h0);
    end_test("plain frame");

    // offset of two whole words, burst of four words
    apb(1'b1, ADDR_RX_CONFIG, 32'h0408);
    u_rxf_mac_model.send(3, 32'h2000, 32'h4000_00a5);
    u_rxf_mac_model.send(3, 32'h3000, 32'h4000_00a5);
    repeat (12) @(posedge clk);
    rd_chk(ADDR_FILL_INFO, fi(2, 16));
    rd_chk(ADDR_STAT_PORT, st(12));
    rd_chk(ADDR_STAT_PORT, st(12));
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 8; i++) begin
        apb(1'b0, ADDR_DATA_PORT, 32'h0);
        if (i < 2) chk(q, 32'h0);
        else if (i < 5) chk(q, 32'h2000 + p * 32'h1000 + i - 2);
      end
    end
    rd_chk(ADDR_FILL_INFO, 32'h0);
    end_test("offset and padding");

    // two-byte offset: every word straddles two lanes, plus a tail word
    apb(1'b1, ADDR_RX_CONFIG, 32'h2);
    u_rxf_mac_model.send(2, 32'ha1b2_c3d4, 32'h4000_00a5);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_STAT_PORT, st(8));
    rd_chk(ADDR_DATA_PORT, 32'hc3d4_0000);
    rd_chk(ADDR_DATA_PORT, 32'hc3d5_a1b2);
    rd_chk(ADDR_DATA_PORT, 32'h0000_a1b2);
    rd_chk(ADDR_FILL_INFO, 32'h0);
    end_test("byte offset");

    apb(1'b1, ADDR_RX_CONFIG, 32'h0);
    u_rxf_mac_model.send(5, 32'h4000, 32'h4000_00a5);
    u_rxf_mac_model.send(2, 32'h5000, 32'h4000_00a5);
    repeat (4) @(posedge clk);
    apb(1'b1, ADDR_DP_CTRL, 32'h8000_0000);
    fork
      u_rxf_mac_model.send(2, 32'h6000, 32'h4000_00a5);
    join_none
    i = 0;
    do begin
      apb(1'b0, ADDR_DP_CTRL, 32'h0);
      i++;
    end while (q[DP_SKIP_BIT] !== 1'b0 && i < 50);
    chk(q, 32'h0);
    repeat (10) @(posedge clk);
    rd_chk(ADDR_FILL_INFO, fi(3, 4));
    for (i = 0; i < 2; i++) rd_chk(ADDR_DATA_PORT, 32'h5000 + i);
    for (i = 0; i < 2; i++) rd_chk(ADDR_DATA_PORT, 32'h6000 + i);
    rd_chk(ADDR_STAT_PORT, st(20));
    rd_chk(ADDR_STAT_PORT, st(8));
    rd_chk(ADDR_STAT_PORT, st(8));
    end_test("skip packet");

    halt_seen = 1'b0;
    apb(1'b1, ADDR_MAC_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    chk({31'h0, halt_seen}, 32'h1);
    rd_chk(ADDR_EVENTS, 32'h2);
    apb(1'b0, ADDR_DATA_PORT, 32'h0);
    chk({31'h0, rx_error}, 32'h1);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_EVENTS, 32'h3);
    apb(1'b1, ADDR_EVENTS, 32'h3);
    rd_chk(ADDR_EVENTS, 32'h0);
    apb(1'b0, ADDR_STAT_PORT, 32'h0);
    chk({31'h0, rx_error}, 32'h1);
    end_test("halt and underrun");

    apb(1'b1, ADDR_MAC_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    rd_chk(ADDR_EVENTS, 32'h0);
    rd_chk(ADDR_MAC_CTRL, 32'h0);
    end_test("soft reset");

    apb(1'b1, ADDR_MAC_CTRL, 32'h1);
    u_rxf_mac_model.send(3, 32'h7000, 32'h4000_00a5);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_FILL_INFO, fi(1, 3));
    halt_seen = 1'b0;
    apb(1'b1, ADDR_MAC_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    chk({31'h0, halt_seen}, 32'h1);
    apb(1'b1, ADDR_RX_CONFIG, 32'h8000);
    rd_chk(ADDR_RX_CONFIG, 32'h0);
    rd_chk(ADDR_FILL_INFO, 32'h0);
    end_test("dump");
    wrap_up;
  end
endmodule
